//--- rtl/twm_bit_engine.sv
// Bit engine: start, repeated start, stop and byte-with-acknowledge
`timescale 1ns/1ns
module twm_bit_engine (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Synchronised bus levels
  input  wire logic scl_s,
  input  wire logic sda_s,
  // Command link
  twm_eng_if.eng    bus,
  // Open-drain drive, high pulls the line low
  output logic      scl_oe_r,
  output logic      sda_oe_r
);
  import twm_pkg::*;

  twm_eng_t         st_r, st_nxt;
  twm_op_t          op_r, op_nxt;
  logic [1:0]       q_r, q_nxt;
  logic [3:0]       bit_r, bit_nxt;
  logic [8:0]       sh_r, sh_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic             scl_nxt, sda_nxt;
  logic             done_r, done_nxt;
  logic             ack_r, ack_nxt;
  logic             arb_r, arb_nxt;
  logic             tick, adv;

  assign tick         = (st_r == E_RUN) && (div_r == DIV_W'(QTR_CYC - 1));
  assign bus.done     = done_r;
  assign bus.ack      = ack_r;
  assign bus.arb_lost = arb_r;

  always_comb begin
    st_nxt   = st_r;
    op_nxt   = op_r;
    q_nxt    = q_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    scl_nxt  = scl_oe_r;
    sda_nxt  = sda_oe_r;
    ack_nxt  = ack_r;
    arb_nxt  = arb_r;
    done_nxt = 1'b0;
    adv      = 1'b0;
    div_nxt  = (st_r == E_RUN && !tick) ? div_r + 1'b1 : '0;
    case (st_r)
      E_IDLE: begin
        if (bus.go) begin
          st_nxt  = E_RUN;
          op_nxt  = bus.cmd;
          q_nxt   = Q0;
          bit_nxt = '0;
          sh_nxt  = {bus.tx_byte, 1'b1};
          ack_nxt = 1'b0;
          arb_nxt = 1'b0;
        end
      end
      default: begin
        if (tick) begin
          adv = 1'b1;
          case (op_r)
            OP_START: begin
              if (q_r == Q0) begin
                sda_nxt = 1'b1;
              end else begin
                scl_nxt  = 1'b1;
                done_nxt = 1'b1;
              end
            end
            OP_RESTART: begin
              case (q_r)
                Q0: sda_nxt = 1'b0;
                Q1: scl_nxt = 1'b0;
                Q2: begin
                  // Waits for a target that stretches the clock
                  if (scl_s) sda_nxt = 1'b1;
                  else adv = 1'b0;
                end
                default: begin
                  scl_nxt  = 1'b1;
                  done_nxt = 1'b1;
                end
              endcase
            end
            OP_STOP: begin
              case (q_r)
                Q0: sda_nxt = 1'b1;
                Q1: scl_nxt = 1'b0;
                default: begin
                  if (scl_s) begin
                    sda_nxt  = 1'b0;
                    done_nxt = 1'b1;
                  end else begin
                    adv = 1'b0;
                  end
                end
              endcase
            end
            default: begin
              case (q_r)
                Q0: sda_nxt = ~sh_r[8];
                Q1: scl_nxt = 1'b0;
                Q2: begin
                  if (!scl_s) begin
                    adv = 1'b0;
                  end else if (bit_r == BIT_ACK) begin
                    ack_nxt = ~sda_s;
                  end else if (sh_r[8] && !sda_s) begin
                    // Another master won: let go of both lines
                    arb_nxt  = 1'b1;
                    scl_nxt  = 1'b0;
                    sda_nxt  = 1'b0;
                    done_nxt = 1'b1;
                  end
                end
                default: begin
                  scl_nxt = 1'b1;
                  sh_nxt  = {sh_r[7:0], 1'b0};
                  bit_nxt = bit_r + 4'h1;
                  if (bit_r == BIT_ACK) done_nxt = 1'b1;
                end
              endcase
            end
          endcase
          if (adv) q_nxt = q_r + 2'h1;
          if (done_nxt) st_nxt = E_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r     <= E_IDLE;
      op_r     <= OP_START;
      q_r      <= Q0;
      bit_r    <= '0;
      sh_r     <= '0;
      div_r    <= '0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      done_r   <= 1'b0;
      ack_r    <= 1'b0;
      arb_r    <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      op_r     <= op_nxt;
      q_r      <= q_nxt;
      bit_r    <= bit_nxt;
      sh_r     <= sh_nxt;
      div_r    <= div_nxt;
      scl_oe_r <= scl_nxt;
      sda_oe_r <= sda_nxt;
      done_r   <= done_nxt;
      ack_r    <= ack_nxt;
      arb_r    <= arb_nxt;
    end
  end

endmodule : twm_bit_engine

//--- rtl/twm_eng_if.sv
// Command and result link between sequencer and bit engine
`timescale 1ns/1ns
interface twm_eng_if;
  import twm_pkg::*;
  logic       go;
  twm_op_t    cmd;
  logic [7:0] tx_byte;
  logic       done;
  logic       ack;
  logic       arb_lost;
  modport ctl (output go, cmd, tx_byte, input done, ack, arb_lost);
  modport eng (input go, cmd, tx_byte, output done, ack, arb_lost);
endinterface : twm_eng_if

//--- rtl/twm_master_tx.sv
// Two-wire master-transmit sequencer: registers, status codes, bus control
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module twm_master_tx (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Interrupt request
  output logic            irq,
  // Serial bus, open drain
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);
  import twm_pkg::*;

  twm_eng_if eng ();

  twm_st_t    st_r, st_nxt;
  twm_op_t    cmd_r, cmd_nxt;
  logic       go_r, go_nxt;
  logic       flag_r, flag_nxt;
  logic       acken_r, acken_nxt;
  logic       start_r, start_nxt;
  logic       stop_r, stop_nxt;
  logic       wcol_r, wcol_nxt;
  logic       en_r, en_nxt;
  logic       irqen_r, irqen_nxt;
  logic [7:0] status_r, status_nxt;
  logic [1:0] presc_r, presc_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       irq_r, irq_nxt;
  logic       is_addr_r, is_addr_nxt;
  logic       rx_mode_r, rx_mode_nxt;
  logic       pend_r, pend_nxt;
  logic       busy_r, busy_nxt;
  logic       scl_m, scl_s, scl_d;
  logic       sda_m, sda_s, sda_d;
  logic       ctrl_wr, stat_wr, data_wr, clr, wsta, wsto, wen;
  logic       tx_code;

  assign ctrl_wr = reg_wr && (reg_addr == ADDR_CTRL);
  assign stat_wr = reg_wr && (reg_addr == ADDR_STAT);
  assign data_wr = reg_wr && (reg_addr == ADDR_DATA);
  assign clr     = ctrl_wr && reg_wdata[CB_FLAG];
  assign wsta    = reg_wdata[CB_START];
  assign wsto    = reg_wdata[CB_STOP];
  assign wen     = reg_wdata[CB_EN];
  assign tx_code = (status_r == ST_AW_ACK) || (status_r == ST_AW_NACK) ||
                   (status_r == ST_D_ACK) || (status_r == ST_D_NACK);

  assign eng.go      = go_r;
  assign eng.cmd     = cmd_r;
  assign eng.tx_byte = data_r;
  assign reg_rdata   = rdata_r;
  assign irq         = irq_r;

  twm_bit_engine u_engine (
    .clock    (clock),
    .rst      (rst),
    .scl_s    (scl_s),
    .sda_s    (sda_s),
    .bus      (eng.eng),
    .scl_oe_r (scl_oe),
    .sda_oe_r (sda_oe)
  );

  // Bus lines come from another domain; two flops before any use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_m   <= 1'b1;
      scl_s   <= 1'b1;
      scl_d   <= 1'b1;
      sda_m   <= 1'b1;
      sda_s   <= 1'b1;
      sda_d   <= 1'b1;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_m   <= scl_in;
      scl_s   <= scl_m;
      scl_d   <= scl_s;
      sda_m   <= sda_in;
      sda_s   <= sda_m;
      sda_d   <= sda_s;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  always_comb begin
    st_nxt      = st_r;
    cmd_nxt     = cmd_r;
    go_nxt      = 1'b0;
    acken_nxt   = acken_r;
    start_nxt   = start_r;
    stop_nxt    = stop_r;
    wcol_nxt    = wcol_r;
    en_nxt      = en_r;
    irqen_nxt   = irqen_r;
    status_nxt  = status_r;
    presc_nxt   = presc_r;
    data_nxt    = data_r;
    is_addr_nxt = is_addr_r;
    rx_mode_nxt = rx_mode_r;
    pend_nxt    = pend_r;
    busy_nxt    = busy_r;
    flag_nxt    = flag_r & ~clr;
    // Bus ownership seen on the lines, for any master
    if (scl_s && scl_d && sda_d && !sda_s) busy_nxt = 1'b1;
    else if (scl_s && scl_d && !sda_d && sda_s) busy_nxt = 1'b0;
    // Acknowledge enable is kept for software only
    if (ctrl_wr) begin
      acken_nxt = reg_wdata[CB_ACKEN];
      start_nxt = wsta;
      stop_nxt  = wsto;
      en_nxt    = wen;
      irqen_nxt = reg_wdata[CB_IRQEN];
    end else if (stat_wr) begin
      presc_nxt = reg_wdata[SP_HI:SP_LO];
    end else if (data_wr) begin
      if (flag_r) begin
        data_nxt = reg_wdata;
        wcol_nxt = 1'b0;
      end else begin
        wcol_nxt = 1'b1;
      end
    end
    case (st_r)
      T_IDLE: begin
        if (clr && wen && wsta) st_nxt = T_WAIT;
      end
      T_WAIT: begin
        if (!en_r) begin
          st_nxt = T_IDLE;
        end else if (!busy_r) begin
          go_nxt  = 1'b1;
          cmd_nxt = OP_START;
          st_nxt  = T_RUN;
        end
      end
      T_RUN: begin
        if (eng.done) begin
          st_nxt   = T_HOLD;
          flag_nxt = 1'b1;
          if (eng.arb_lost) begin
            status_nxt  = ST_ARB;
            rx_mode_nxt = 1'b0;
          end else if (cmd_r == OP_START) begin
            status_nxt = ST_START;
          end else if (cmd_r == OP_RESTART) begin
            status_nxt = ST_RESTART;
          end else if (cmd_r == OP_STOP) begin
            flag_nxt = flag_r & ~clr;
            stop_nxt = 1'b0;
            pend_nxt = 1'b0;
            if (pend_r) begin
              st_nxt = T_WAIT;
            end else begin
              st_nxt     = T_IDLE;
              status_nxt = ST_IDLE;
            end
          end else if (is_addr_r) begin
            rx_mode_nxt = data_r[DIR_BIT];
            if (data_r[DIR_BIT])
              status_nxt = eng.ack ? ST_AR_ACK : ST_AR_NACK;
            else
              status_nxt = eng.ack ? ST_AW_ACK : ST_AW_NACK;
          end else begin
            status_nxt = eng.ack ? ST_D_ACK : ST_D_NACK;
          end
        end
      end
      default: begin
        // Except after lost arbitration, the bus stays held until software clears the flag
        if (clr && wen) begin
          if (status_r == ST_ARB) begin
            if (wsta) begin
              st_nxt = T_WAIT;
            end else begin
              st_nxt     = T_IDLE;
              status_nxt = ST_IDLE;
            end
          end else if (wsto) begin
            go_nxt   = 1'b1;
            cmd_nxt  = OP_STOP;
            st_nxt   = T_RUN;
            pend_nxt = wsta;
          end else if (wsta) begin
            go_nxt  = 1'b1;
            cmd_nxt = OP_RESTART;
            st_nxt  = T_RUN;
          end else if (status_r == ST_START || status_r == ST_RESTART) begin
            go_nxt      = 1'b1;
            cmd_nxt     = OP_BYTE;
            is_addr_nxt = 1'b1;
            st_nxt      = T_RUN;
          end else if (tx_code) begin
            go_nxt      = 1'b1;
            cmd_nxt     = OP_BYTE;
            is_addr_nxt = 1'b0;
            st_nxt      = T_RUN;
          end
        end
      end
    endcase
    irq_nxt   = flag_r && irqen_r;
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (reg_addr == ADDR_CTRL)
        rdata_nxt = {flag_r, acken_r, start_r, stop_r,
                     wcol_r, en_r, 1'b0, irqen_r};
      else if (reg_addr == ADDR_STAT)
        rdata_nxt = (status_r & CODE_MASK) | {6'h00, presc_r};
      else if (reg_addr == ADDR_DATA)
        rdata_nxt = data_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r      <= T_IDLE;
      cmd_r     <= OP_START;
      go_r      <= 1'b0;
      flag_r    <= 1'b0;
      acken_r   <= 1'b0;
      start_r   <= 1'b0;
      stop_r    <= 1'b0;
      wcol_r    <= 1'b0;
      en_r      <= 1'b0;
      irqen_r   <= 1'b0;
      status_r  <= ST_IDLE;
      presc_r   <= PRESC_RST;
      data_r    <= DATA_RST;
      rdata_r   <= 8'h00;
      irq_r     <= 1'b0;
      is_addr_r <= 1'b0;
      rx_mode_r <= 1'b0;
      pend_r    <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cmd_r     <= cmd_nxt;
      go_r      <= go_nxt;
      flag_r    <= flag_nxt;
      acken_r   <= acken_nxt;
      start_r   <= start_nxt;
      stop_r    <= stop_nxt;
      wcol_r    <= wcol_nxt;
      en_r      <= en_nxt;
      irqen_r   <= irqen_nxt;
      status_r  <= status_nxt;
      presc_r   <= presc_nxt;
      data_r    <= data_nxt;
      rdata_r   <= rdata_nxt;
      irq_r     <= irq_nxt;
      is_addr_r <= is_addr_nxt;
      rx_mode_r <= rx_mode_nxt;
      pend_r    <= pend_nxt;
      busy_r    <= busy_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_start_when_free: assert property (
    (go_r && cmd_r == OP_START) |-> !$past(busy_r))
    else $error("START launched while bus busy");
  a_start_code: assert property (
    (st_r == T_RUN && cmd_r == OP_START && eng.done && !eng.arb_lost)
    |=> (flag_r && status_r == ST_START))
    else $error("START did not report 0x08");
  a_code_masked: assert property (
    (status_r & ~CODE_MASK) == 8'h00)
    else $error("Status code has low bits set");
  a_addr_mode: assert property (
    (st_r == T_RUN && eng.done && is_addr_r && !eng.arb_lost
     && cmd_r == OP_BYTE) |=> rx_mode_r == $past(data_r[DIR_BIT]))
    else $error("Mode does not follow direction bit");
  a_addr_launch: assert property (
    (st_r == T_HOLD && clr && wen && !wsta && !wsto
     && status_r == ST_START) |=> (go_r && cmd_r == OP_BYTE && is_addr_r))
    else $error("Address not sent after flag clear");
  a_addr_result: assert property (
    (st_r == T_RUN && eng.done && is_addr_r && cmd_r == OP_BYTE
     && !data_r[DIR_BIT]) |=> status_r ==
    ($past(eng.arb_lost) ? ST_ARB : ($past(eng.ack) ? ST_AW_ACK : ST_AW_NACK)))
    else $error("Wrong code after write address");
  a_wcol_drop: assert property (
    (data_wr && !flag_r) |=> (wcol_r && $stable(data_r)))
    else $error("Data write with flag low not rejected");
  a_data_result: assert property (
    (st_r == T_RUN && eng.done && !is_addr_r && cmd_r == OP_BYTE
     && !eng.arb_lost) |=> (flag_r && status_r ==
    ($past(eng.ack) ? ST_D_ACK : ST_D_NACK)))
    else $error("Wrong code after data byte");
  a_stop_self_clear: assert property (
    (st_r == T_RUN && eng.done && cmd_r == OP_STOP) |=> !stop_r)
    else $error("Stop bit not cleared after STOP");
  a_restart_code: assert property (
    (go_r && cmd_r == OP_RESTART) |-> ##[1:40] (flag_r && status_r ==
    ST_RESTART))
    else $error("Repeated START not reported");
  a_arb_release: assert property (
    (st_r == T_HOLD && status_r == ST_ARB && clr && wen && !wsta)
    |=> (st_r == T_IDLE && status_r == ST_IDLE && !scl_oe))
    else $error("Bus not released after lost arbitration");
  a_hold_bus: assert property (
    (st_r == T_HOLD && !clr) |=> (st_r == T_HOLD && $stable(scl_oe)))
    else $error("Transfer moved while flag set");
  a_irq_follow: assert property (
    irq == $past(flag_r && irqen_r))
    else $error("Interrupt request not raised");

  c_start_sent: cover property (st_r == T_RUN ##[1:20] status_r == ST_START);
  c_addr_ack:   cover property (status_r == ST_AW_ACK && flag_r);
  c_data_ack:   cover property (status_r == ST_D_ACK && flag_r);
  c_stop_start: cover property (pend_r && st_r == T_WAIT);

endmodule : twm_master_tx

//--- rtl/twm_pkg.sv
// Constants and types shared by the two-wire master-transmit sequencer
package twm_pkg;

  // Timing: one quarter of a serial clock period
  localparam int CLK_NS  = 40;
  localparam int QTR_NS  = 80;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIV_W   = 4;

  // Register offsets on the register port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;

  // Control register bit positions
  localparam int CB_FLAG  = 7;
  localparam int CB_ACKEN = 6;
  localparam int CB_START = 5;
  localparam int CB_STOP  = 4;
  localparam int CB_WCOL  = 3;
  localparam int CB_EN    = 2;
  localparam int CB_IRQEN = 0;

  // Status register fields, and the direction bit of the address byte
  localparam int         SP_HI     = 1;
  localparam int         SP_LO     = 0;
  localparam logic [7:0] CODE_MASK = 8'hf8;
  localparam int         DIR_BIT   = 0;

  // Status codes
  localparam logic [7:0] ST_START   = 8'h08;
  localparam logic [7:0] ST_RESTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK  = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_D_ACK   = 8'h28;
  localparam logic [7:0] ST_D_NACK  = 8'h30;
  localparam logic [7:0] ST_ARB     = 8'h38;
  localparam logic [7:0] ST_AR_ACK  = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_IDLE    = 8'hf8;

  // Reset values
  localparam logic [7:0] DATA_RST  = 8'hff;
  localparam logic [1:0] PRESC_RST = 2'h0;

  // Bit engine step indices
  localparam logic [1:0] Q0      = 2'h0;
  localparam logic [1:0] Q1      = 2'h1;
  localparam logic [1:0] Q2      = 2'h2;
  localparam logic [1:0] Q3      = 2'h3;
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum logic [3:0] {
    OP_START   = 4'b0001,
    OP_RESTART = 4'b0010,
    OP_STOP    = 4'b0100,
    OP_BYTE    = 4'b1000
  } twm_op_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b01,
    E_RUN  = 2'b10
  } twm_eng_t;

  typedef enum logic [3:0] {
    T_IDLE = 4'b0001,
    T_WAIT = 4'b0010,
    T_RUN  = 4'b0100,
    T_HOLD = 4'b1000
  } twm_st_t;

endpackage : twm_pkg

//--- verif/tb.sv
// Bench: register sequences against the target model on the bus
`timescale 1ns/1ns
module tb;
  import twm_pkg::*;
  logic       clock, rst, reg_wr, reg_rd, irq;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, rx;
  logic       scl_out, scl_oe, sda_out, sda_oe, t_oe, nack, grab;
  logic [7:0] rv [4];
  int         n_start, n_stop, n_mismatch, n_compared, i;
  // Open drain with pull-ups
  wire        scl_w = !scl_oe;
  wire        sda_w = !(sda_oe | t_oe);
  twm_master_tx i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  twm_target i_tgt (.scl(scl_w), .sda(sda_w), .nack(nack), .grab(grab),
    .sda_oe(t_oe), .rx_byte(rx), .n_start(n_start), .n_stop(n_stop));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task wrap_up;
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // A gap cycle after each strobe keeps one assignment per time step
  task wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask : rd
  // Data 0x00 means no data load; codes are compared masked
  task step(input logic [7:0] d, input logic [7:0] c, input logic [7:0] e);
    int k;
    if (d !== 8'h00) wr(ADDR_DATA, d);
    wr(ADDR_CTRL, c);
    v = 8'h00;
    for (k = 0; k < 300 && v[CB_FLAG] !== 1'b1 && e != ST_IDLE; k++)
      rd(ADDR_CTRL, v);
    v = 8'h00;
    for (k = 0; k < 300 && (v & CODE_MASK) !== e; k++) rd(ADDR_STAT, v);
    chk("status", v & CODE_MASK, e);
  endtask : step
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    wrap_up;
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, nack, grab} = '0;
    rst = 1'b1;
    rv = '{8'h00, ST_IDLE, DATA_RST, 8'h00};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 4; i++) begin
      rd(i[1:0], v);
      chk("reset value", v, rv[i]);
    end
    wr(ADDR_STAT, 8'h03);
    rd(ADDR_STAT, v);
    chk("prescaler", v, ST_IDLE | 8'h03);
    wr(ADDR_DATA, 8'h12);
    rd(ADDR_CTRL, v);
    chk("collision", v, 8'h08);
    rd(ADDR_DATA, v);
    chk("data kept", v, DATA_RST);
    wr(ADDR_CTRL, 8'ha1);
    repeat (100) @(posedge clock);
    chk("no start", n_start[7:0], 8'h00);
    step(8'h00, 8'ha5, ST_START);
    chk("irq", {7'h0, irq}, 8'h01);
    repeat (40) @(posedge clock);
    chk("scl held", {7'h0, scl_oe}, 8'h01);
    step(8'ha4, 8'hc5, ST_AW_ACK);
    rd(ADDR_CTRL, v);
    chk("ctrl", v, 8'hc5);
    chk("address", rx, 8'ha4);
    step(8'h5a, 8'h85, ST_D_ACK);
    chk("data", rx, 8'h5a);
    nack <= 1'b1;
    step(8'h3c, 8'h85, ST_D_NACK);
    step(8'h00, 8'ha5, ST_RESTART);
    chk("stops", n_stop[7:0], 8'h00);
    step(8'ha6, 8'h85, ST_AW_NACK);
    nack <= 1'b0;
    step(8'h00, 8'hb5, ST_START);
    chk("stops", n_stop[7:0], 8'h01);
    rd(ADDR_CTRL, v);
    chk("stop bit", v & 8'h10, 8'h00);
    step(8'ha4, 8'h85, ST_AW_ACK);
    step(8'h00, 8'ha5, ST_RESTART);
    nack <= 1'b1;
    step(8'ha1, 8'h85, ST_AR_NACK);
    chk("read addr", rx, 8'ha1);
    step(8'h00, 8'h95, ST_IDLE);
    rd(ADDR_CTRL, v);
    chk("ctrl", v, 8'h05);
    chk("irq", {7'h0, irq}, 8'h00);
    chk("stops", n_stop[7:0], 8'h02);
    nack <= 1'b0;
    grab <= 1'b1;
    step(8'h00, 8'ha5, ST_START);
    step(8'ha4, 8'h85, ST_ARB);
    grab <= 1'b0;
    step(8'h00, 8'ha5, ST_START);
    grab <= 1'b1;
    step(8'ha4, 8'h85, ST_ARB);
    grab <= 1'b0;
    step(8'h00, 8'h85, ST_IDLE);
    chk("released", {6'h0, scl_oe, sda_oe}, 8'h00);
    chk("out pins", {6'h0, scl_out, sda_out}, 8'h00);
    wrap_up;
  end
endmodule : tb

//--- verif/twm_target.sv
// Target device model: acknowledges bytes and can contend for the data line
`timescale 1ns/1ns
module twm_target (
  // Bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour controls
  input  wire logic       nack,
  input  wire logic       grab,
  // Drive and observation
  output logic            sda_oe,
  output logic      [7:0] rx_byte,
  output int              n_start,
  output int              n_stop
);
  logic [7:0] sh;
  logic       on;
  logic       ack_d;
  logic       g;
  int         cnt;
  initial begin
    {sh, rx_byte, on, ack_d, g} = '0;
    cnt = 0;
    n_start = 0;
    n_stop = 0;
  end
  // Contention is dropped at once so a STOP can show on the wire
  assign sda_oe = ack_d | (g & grab);
  always @(negedge sda) if (scl) begin
    on = 1'b1;
    cnt = 0;
    n_start++;
  end
  always @(posedge sda) if (scl && on) begin
    on = 1'b0;
    n_stop++;
  end
  always @(posedge scl) if (on) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    cnt++;
  end
  // Changes land while the clock line is low, never across a high phase
  always @(negedge scl) begin
    g <= on && cnt < 8;
    ack_d <= on && cnt == 8 && !nack;
    if (cnt == 8) rx_byte <= sh;
    if (cnt >= 9) cnt = 0;
  end
endmodule : twm_target
